// [src/port_four_pkg.sv]
// constants and types for the four-pin shared-function port
package port_four_pkg;

    // ------------------------------------------------------------
    // register indices and byte addresses
    // ------------------------------------------------------------
    localparam logic [15:0] DATA_IDX = 16'hFFD7;
    localparam logic [15:0] DIR_IDX = 16'hFFE7;
    localparam logic [15:0] SHARE_IDX = 16'h0010;
    localparam logic [15:0] POWER_IDX = 16'h0011;
    localparam logic [31:0] DATA_ADDR = {14'h0000, DATA_IDX, 2'h0};
    localparam logic [31:0] DIR_ADDR = {14'h0000, DIR_IDX, 2'h0};
    localparam logic [31:0] SHARE_ADDR = {14'h0000, SHARE_IDX, 2'h0};
    localparam logic [31:0] POWER_ADDR = {14'h0000, POWER_IDX, 2'h0};

    // ------------------------------------------------------------
    // reset values and fixed read values
    // ------------------------------------------------------------
    localparam logic [7:0] DATA_RESET = 8'hF8;
    localparam logic [7:0] DIR_RESET = 8'hF8;
    localparam logic [7:0] DIR_READ = 8'hFF;
    localparam logic [3:0] DATA_HIGH_BITS = 4'hF;
    localparam logic [5:0] SHARE_RESET = 6'h00;

    // ------------------------------------------------------------
    // sharing register field positions
    // ------------------------------------------------------------
    localparam int TRANSMIT_ENABLE_POS = 0;
    localparam int RX_ENABLE_BIT_POS = 1;
    localparam int CLK_SRC_LO_BIT_POS = 2;
    localparam int CLK_SRC_HI_BIT_POS = 3;
    localparam int CLOCKED_MODE_POS = 4;
    localparam int EXT_IRQ_SEL_POS = 5;

    // ------------------------------------------------------------
    // bus answers
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        PWR_ACTIVE,
        PWR_SUBACTIVE,
        PWR_SLEEP,
        PWR_SUBSLEEP,
        PWR_WATCH,
        PWR_STANDBY
    } power_mode_e;

    localparam power_mode_e POWER_RESET = PWR_ACTIVE;

endpackage

// [src/port_four_gpio.sv]
// four-pin port with serial and interrupt sharing, AXI4-Lite registers
// Behaviour
// - three two-way pins on bits 2..0, input-only pin on bit 3
// - data read gives latch where direction is 1, pin level where 0
// - data bit 3 is read-only and always shows the input pin level
// - data register resets to F8: high bits one, latches cleared
// - direction bit 1 drives latch onto pin, 0 makes it input
// - direction register is write-only and always reads all ones
// - direction register resets to F8, pins start as inputs
// - latch and direction only act where the pin is general I/O
// - transmit enable makes pin 2 serial transmit output over direction
// - pin 0 general, serial clock out or in from clock bits and clocked mode bit
// - pins float in reset and standby, hold in sleep modes
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

module port_four_gpio (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [3:0] pin_in,
    output logic [2:0] pin_out,
    output logic [2:0] pin_oe,
    input wire logic serial_tx_data,
    input wire logic serial_clock_out,
    output logic serial_rx_data,
    output logic serial_clock_in,
    output logic ext_interrupt_zero
);
    import port_four_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] latch;
        logic [2:0] dir;
        logic [5:0] share;
        power_mode_e pwr;
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [3:0] sync3;
        logic [3:0] lvl;
        logic [2:0] pout;
        logic [2:0] poe;
        logic aw_have;
        logic [31:0] awaddr;
        logic w_have;
        logic [7:0] wbyte;
        logic wlane;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_s;

    state_s q;
    state_s d;

    logic transmit_enable;
    logic rx_enable_bit;
    logic clk_src_lo_bit;
    logic clk_src_hi_bit;
    logic clocked_mode;
    logic ext_irq_sel;
    logic clk_pin_out;
    logic [2:0] fn_out;
    logic [2:0] fn_oe;
    logic [7:0] data_view;

    assign transmit_enable = q.share[TRANSMIT_ENABLE_POS];
    assign rx_enable_bit = q.share[RX_ENABLE_BIT_POS];
    assign clk_src_lo_bit = q.share[CLK_SRC_LO_BIT_POS];
    assign clk_src_hi_bit = q.share[CLK_SRC_HI_BIT_POS];
    assign clocked_mode = q.share[CLOCKED_MODE_POS];
    assign ext_irq_sel = q.share[EXT_IRQ_SEL_POS];

    // ------------------------------------------------------------
    // pin function selection
    // ------------------------------------------------------------
    assign clk_pin_out = !clk_src_hi_bit && (clk_src_lo_bit || clocked_mode);

    always_comb begin
        fn_out = q.latch;
        fn_oe = q.dir;
        if (transmit_enable) begin
            fn_out[2] = serial_tx_data;
            fn_oe[2] = 1'b1;
        end
        if (rx_enable_bit) begin
            fn_oe[1] = 1'b0;
        end
        if (clk_src_hi_bit) begin
            fn_oe[0] = 1'b0;
        end else if (clk_pin_out) begin
            fn_out[0] = serial_clock_out;
            fn_oe[0] = 1'b1;
        end
    end

    assign serial_rx_data = rx_enable_bit ? q.lvl[1] : 1'b1;
    assign serial_clock_in = clk_src_hi_bit ? q.lvl[0] : 1'b0;
    assign ext_interrupt_zero = ext_irq_sel ? q.lvl[3] : 1'b1;

    // ------------------------------------------------------------
    // data register read view
    // ------------------------------------------------------------
    always_comb begin
        data_view[7:4] = DATA_HIGH_BITS;
        data_view[3] = q.lvl[3];
        for (int i = 0; i < 3; i++) begin
            data_view[i] = q.dir[i] ? q.latch[i] : q.lvl[i];
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.sync1 = pin_in;
        d.sync2 = q.sync1;
        d.sync3 = q.sync2;
        for (int i = 0; i < 4; i++) begin
            if (q.sync2[i] == q.sync3[i]) begin
                d.lvl[i] = q.sync2[i];
            end
        end
        case (q.pwr)
            PWR_STANDBY: begin
                d.poe = 3'h0;
            end
            PWR_SLEEP, PWR_SUBSLEEP, PWR_WATCH: begin
                d.pout = q.pout;
            end
            default: begin
                d.pout = fn_out;
                d.poe = fn_oe;
            end
        endcase
        // write channel
        if (s_axi_awvalid && s_axi_awready) begin
            d.aw_have = 1'b1;
            d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            d.w_have = 1'b1;
            d.wbyte = s_axi_wdata[7:0];
            d.wlane = s_axi_wstrb[0];
        end
        if (q.aw_have && q.w_have) begin
            d.aw_have = 1'b0;
            d.w_have = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = RESP_OKAY;
            case (q.awaddr)
                DATA_ADDR: begin
                    if (q.wlane) begin
                        d.latch = q.wbyte[2:0];
                    end
                end
                DIR_ADDR: begin
                    if (q.wlane) begin
                        d.dir = q.wbyte[2:0];
                    end
                end
                SHARE_ADDR: begin
                    if (q.wlane) begin
                        d.share = q.wbyte[5:0];
                    end
                end
                POWER_ADDR: begin
                    if (q.wlane) begin
                        d.pwr = power_mode_e'(q.wbyte[2:0]);
                    end
                end
                default: begin
                    d.bresp = RESP_SLVERR;
                end
            endcase
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        // read channel
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            d.rvalid = 1'b1;
            d.rresp = RESP_OKAY;
            case (s_axi_araddr)
                DATA_ADDR: d.rdata = {24'h000000, data_view};
                DIR_ADDR: d.rdata = {24'h000000, DIR_READ};
                SHARE_ADDR: d.rdata = {26'h0000000, q.share};
                POWER_ADDR: d.rdata = {29'h00000000, q.pwr};
                default: begin
                    d.rdata = 32'h00000000;
                    d.rresp = RESP_SLVERR;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.latch <= DATA_RESET[2:0];
            q.dir <= DIR_RESET[2:0];
            q.share <= SHARE_RESET;
            q.pwr <= POWER_RESET;
            q.poe <= 3'h0;
        end else begin
            q <= d;
        end
    end

    assign s_axi_awready = !q.aw_have && !q.bvalid;
    assign s_axi_wready = !q.w_have && !q.bvalid;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign pin_out = q.pout;
    assign pin_oe = q.poe;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic rd_data;
    logic rd_dir;
    logic live;
    assign rd_data = s_axi_arvalid && s_axi_arready && s_axi_araddr == DATA_ADDR;
    assign rd_dir = s_axi_arvalid && s_axi_arready && s_axi_araddr == DIR_ADDR;
    assign live = q.pwr == PWR_ACTIVE || q.pwr == PWR_SUBACTIVE;

    property p_read_latch;
        rd_data && q.dir[0] |=> s_axi_rvalid && s_axi_rdata[0] == $past(q.latch[0]);
    endproperty
    a_read_latch: assert property (p_read_latch) else $error("latch not read back");

    property p_read_pin;
        rd_data && !q.dir[1] |=> s_axi_rdata[1] == $past(q.lvl[1]);
    endproperty
    a_read_pin: assert property (p_read_pin) else $error("pin level not read back");

    property p_read_input;
        rd_data |=> s_axi_rdata[7:3] == {4'hF, $past(q.lvl[3])};
    endproperty
    a_read_input: assert property (p_read_input) else $error("bit 3 or high bits wrong");

    property p_dir_ones;
        rd_dir |=> s_axi_rvalid && s_axi_rdata[7:0] == 8'hFF;
    endproperty
    a_dir_ones: assert property (p_dir_ones) else $error("direction read not ones");

    property p_reset_state;
        disable iff (1'b0) !aresetn |=> q.latch == 3'h0 && q.dir == 3'h0 && pin_oe == 3'h0;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

    property p_gpio_drive;
        live && !transmit_enable && q.dir[2] |=> pin_oe[2] && pin_out[2] == $past(q.latch[2]);
    endproperty
    a_gpio_drive: assert property (p_gpio_drive) else $error("pin 2 not driving latch");

    property p_tx_pin;
        live && transmit_enable |=> pin_oe[2] && pin_out[2] == $past(serial_tx_data);
    endproperty
    a_tx_pin: assert property (p_tx_pin) else $error("transmit pin wrong");

    property p_rx_pin;
        live && rx_enable_bit |=> !pin_oe[1];
    endproperty
    a_rx_pin: assert property (p_rx_pin) else $error("receive pin driven");

    property p_clk_pin;
        live && clk_src_hi_bit |-> serial_clock_in == q.lvl[0] ##1 !pin_oe[0];
    endproperty
    a_clk_pin: assert property (p_clk_pin) else $error("clock input pin wrong");

    property p_standby;
        q.pwr == PWR_STANDBY |=> pin_oe == 3'h0;
    endproperty
    a_standby: assert property (p_standby) else $error("pins driven in standby");

    property p_hold;
        q.pwr == PWR_SLEEP |=> $stable(pin_oe) && $stable(pin_out);
    endproperty
    a_hold: assert property (p_hold) else $error("pins changed in sleep");

    property p_irq_route;
        !ext_irq_sel |-> ext_interrupt_zero;
    endproperty
    a_irq_route: assert property (p_irq_route) else $error("interrupt fed while unselected");

endmodule

`default_nettype wire

// [verif/board_pins.sv]
// board-side model of the four port pins
`timescale 1ns/10ps
`default_nettype none

module board_pins (
    input wire logic [2:0] pin_out,
    input wire logic [2:0] pin_oe,
    input wire logic [3:0] ext_level,
    input wire logic clash,
    output logic [3:0] pin_in
);
    // ------------------------------------------------------------
    // pin resolution, board may overpower the port on command
    // ------------------------------------------------------------
    assign pin_in = clash ? ext_level :
        {ext_level[3], (pin_oe & pin_out) | (~pin_oe & ext_level[2:0])};
endmodule

`default_nettype wire

// [verif/port_four_gpio_with_pin_sharing_test.sv]
// self-checking bench for the four-pin shared-function port
`timescale 1ns/10ps
`default_nettype none

module port_four_gpio_with_pin_sharing_test;
    import port_four_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic aclk = 0, aresetn = 0;
    logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 0, pin_in, ext = 4'h9, lv;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [2:0] pin_out, pin_oe, lt, dr;
    logic serial_tx_data = 0, serial_clock_out = 0, clash = 0;
    logic serial_rx_data, serial_clock_in, ext_interrupt_zero;
    logic [5:0] sh, dv;
    int bad_count = 0, n_compared = 0, seed_dummy;

    always #20 aclk = ~aclk;

    port_four_gpio uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out,
        .pin_oe, .serial_tx_data, .serial_clock_out, .serial_rx_data, .serial_clock_in,
        .ext_interrupt_zero);
    board_pins board (.pin_out, .pin_oe, .ext_level(ext), .clash, .pin_in);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task give_verdict;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task axw(input logic [31:0] a, input logic [7:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'hA5C3E1, d};
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // expected {oe, out} of pins 2..0
    function automatic logic [5:0] drive(input logic [2:0] l, input logic [2:0] d,
        input logic [5:0] s, input logic t, input logic c);
        logic [2:0] oe;
        logic [2:0] o;
        oe = d;
        o = l;
        if (s[0]) begin
            oe[2] = 1'b1;
            o[2] = t;
        end
        if (s[1]) oe[1] = 1'b0;
        if (s[3]) oe[0] = 1'b0;
        else if (s[2] || s[4]) begin
            oe[0] = 1'b1;
            o[0] = c;
        end
        return {oe, o};
    endfunction

    task settle;
        repeat (8) @(posedge aclk);
        #1;
    endtask

    task setup;
        axw(DATA_ADDR, {5'h15, lt}, resp);
        axw(DIR_ADDR, {5'h1F, dr}, resp);
        axw(SHARE_ADDR, {2'h0, sh}, resp);
        settle;
    endtask

    task check_pins;
        dv = drive(lt, dr, sh, serial_tx_data, serial_clock_out);
        lv = {ext[3], clash ? ext[2:0] : (dv[5:3] & dv[2:0]) | (~dv[5:3] & ext[2:0])};
        chk("pin_oe", {29'h0, dv[5:3]}, {29'h0, pin_oe});
        chk("pin_out", {29'h0, dv[5:3] & dv[2:0]}, {29'h0, pin_out & pin_oe});
        chk("rx", {31'h0, sh[1] ? lv[1] : 1'b1}, {31'h0, serial_rx_data});
        chk("clk_in", {31'h0, sh[3] ? lv[0] : 1'b0}, {31'h0, serial_clock_in});
        chk("ext_interrupt_zero", {31'h0, sh[5] ? lv[3] : 1'b1}, {31'h0, ext_interrupt_zero});
        axr(DATA_ADDR, rd, resp);
        chk("data", {24'h0, DATA_HIGH_BITS, lv[3], (dr & lt) | (~dr & lv[2:0])}, rd);
        chk("data_rresp", {30'h0, RESP_OKAY}, {30'h0, resp});
        axr(SHARE_ADDR, rd, resp);
        chk("share", {26'h0, sh}, rd);
        axr(DIR_ADDR, rd, resp);
        chk("dir", {24'h0, DIR_READ}, rd);
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (30000) @(posedge aclk);
        bad_count++;
        $display("MISMATCH watchdog expected finish seen timeout");
        give_verdict;
    end

    initial begin
        seed_dummy = $urandom(32'h85003D53);
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        lt = 3'h0;
        dr = 3'h0;
        sh = 6'h00;
        settle;
        check_pins;
        $display("test reset done");
        for (int i = 0; i < 72; i++) begin
            @(posedge aclk);
            ext <= 4'($urandom);
            clash <= ($urandom % 4) == 0;
            serial_tx_data <= 1'($urandom);
            serial_clock_out <= 1'($urandom);
            lt = 3'($urandom);
            dr = 3'($urandom);
            sh = (i < 64) ? i[5:0] : 6'($urandom);
            setup;
            check_pins;
        end
        $display("test sharing done");
        @(posedge aclk);
        clash <= 1'b0;
        dr = 3'h7;
        sh = 6'h00;
        for (int m = 0; m < 8; m++) begin
            lt = 3'h5;
            axw(POWER_ADDR, 8'h00, resp);
            setup;
            axw(POWER_ADDR, 8'(m), resp);
            lt = 3'h2;
            setup;
            chk("pin_oe", {29'h0, (m == 5) ? 3'h0 : 3'h7}, {29'h0, pin_oe});
            if (m != 5) chk("pin_out", {29'h0, (m < 2 || m > 5) ? 3'h2 : 3'h5}, {29'h0, pin_out});
        end
        axw(POWER_ADDR, 8'h00, resp);
        $display("test power done");
        axw(32'h00000200, 8'h07, resp);
        chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
        axr(32'h00000200, rd, resp);
        chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
        $display("test unmapped done");
        lt = 3'h7;
        setup;
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        #1;
        chk("pin_oe", 32'h0, {29'h0, pin_oe});
        @(posedge aclk);
        aresetn <= 1'b1;
        lt = 3'h0;
        dr = 3'h0;
        settle;
        check_pins;
        dr = 3'h7;
        axw(DIR_ADDR, {5'h0, dr}, resp);
        settle;
        check_pins;
        $display("test second reset done");
        give_verdict;
    end
endmodule

`default_nettype wire
